// ==== rtl/psvu_pkg.sv ====
package psvu_pkg;

    // ------------------------------------------------------------
    // address space
    // ------------------------------------------------------------
    localparam int PC_W        = 21;
    localparam int SP_W        = 5;
    localparam int STACK_DEPTH = 31;
    localparam int WORD_W      = 16;

    localparam logic [PC_W-1:0] RESET_VECTOR = 21'h0_0000;
    localparam logic [PC_W-1:0] HIGH_VECTOR  = 21'h0_0008;
    localparam logic [PC_W-1:0] LOW_VECTOR   = 21'h0_0018;
    localparam logic [PC_W-1:0] PC_STEP      = 21'h0_0002;
    localparam logic [SP_W-1:0] SP_RESET     = 5'h00;
    localparam logic [SP_W-1:0] SP_FULL      = 5'h1f;
    localparam logic [WORD_W-1:0] NOP_WORD   = 16'h0000;

    // implemented flash sizes in bytes
    localparam int FLASH_32K = 32768;
    localparam int FLASH_64K = 65536;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic high_req;
        logic low_req;
        logic high_en;
        logic low_en;
    } psvu_irq_s;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] high;
        logic [7:0] low;
    } psvu_tos_s;

    typedef enum logic [1:0] {
        PSVU_RUN,
        PSVU_SLEEP
    } psvu_state_e;

endpackage : psvu_pkg

// ==== rtl/psvu_stack_mem.sv ====
`timescale 1ns/1ps
// return stack storage, registered read
module psvu_stack_mem
    import psvu_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int AW    = SP_W,
    parameter int DW    = PC_W
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    initial begin
        if (DEPTH >= (1 << AW)) $error("stack depth too large");
    end

    logic [DW-1:0] mem [1:DEPTH];

    // write port and registered read
    always_ff @(posedge clk) begin
        if (we && waddr != '0) begin
            mem[waddr] <= wdata;
        end
        if (raddr == '0) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : psvu_stack_mem

// ==== rtl/psvu_top.sv ====
`timescale 1ns/1ps
// Function
// - program counter is 21 bits, covering a 2-Mbyte byte space
// - fetches above implemented flash return zero, a no-operation
// - every reset loads the counter with vector zero
// - taken high-priority interrupt loads vector 0008h
// - taken low-priority interrupt loads vector 0018h
// - enabled interrupt wake-up loads the matching vector
// - enabled interrupt wake-up writes counter into top-of-stack bytes
// - enabled interrupt wake-up advances the stack pointer
// - wake-up is caused by and shown in interrupt flag bits
// - program fetch bus is separate from the data bus
// - implemented flash is 32 Kbytes or 64 Kbytes
// - counter bit zero stays zero; sequential step is two
// - stack pointer is zero after every reset
module psvu_top
    import psvu_pkg::*;
#(
    parameter int FLASH_BYTES = FLASH_64K
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              soft_reset,
    input  wire logic              sleep_req,
    input  wire logic              advance,
    input  wire psvu_irq_s         irq,
    input  wire logic [7:0]        interrupt_control_regs,
    input  wire logic [7:0]        peripheral_irq_flag_regs,
    input  wire logic [WORD_W-1:0] flash_rdata,
    output logic [PC_W-1:0]        fetch_addr,
    output logic                   fetch_valid,
    output logic [WORD_W-1:0]      fetch_word,
    output psvu_tos_s              tos,
    output logic [SP_W-1:0]        return_stack_pointer,
    output logic                   stack_full,
    output logic                   asleep,
    output logic                   vector_taken
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    initial begin
        if (FLASH_BYTES != FLASH_32K && FLASH_BYTES != FLASH_64K) begin
            $error("flash size must be 32 or 64 Kbytes");
        end
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;

    // two-stage release of asynchronous reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // released copy of reset used everywhere else
    logic rst_n;
    assign rst_n = rst_s2_q;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [3:0] irq_s1_q;
    logic [3:0] irq_s2_q;
    logic [1:0] ctl_s1_q;
    logic [1:0] ctl_s2_q;
    logic [7:0] icr_s1_q;
    logic [7:0] icr_s2_q;
    logic [7:0] pir_s1_q;
    logic [7:0] pir_s2_q;

    logic [3:0] irq_s1_d;
    logic [3:0] irq_s2_d;
    logic [1:0] ctl_s1_d;
    logic [1:0] ctl_s2_d;
    logic [7:0] icr_s1_d;
    logic [7:0] icr_s2_d;
    logic [7:0] pir_s1_d;
    logic [7:0] pir_s2_d;

    // next stage values; only the second stage reads the first
    always_comb begin
        irq_s1_d = irq;
        irq_s2_d = irq_s1_q;
        ctl_s1_d = {soft_reset, sleep_req};
        ctl_s2_d = ctl_s1_q;
        icr_s1_d = interrupt_control_regs;
        icr_s2_d = icr_s1_q;
        pir_s1_d = peripheral_irq_flag_regs;
        pir_s2_d = pir_s1_q;
    end

    // request, control and flag pins pass two flops; advance and flash_rdata do not
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1_q <= 4'h0;
            irq_s2_q <= 4'h0;
            ctl_s1_q <= 2'h0;
            ctl_s2_q <= 2'h0;
            icr_s1_q <= 8'h00;
            icr_s2_q <= 8'h00;
            pir_s1_q <= 8'h00;
            pir_s2_q <= 8'h00;
        end else begin
            irq_s1_q <= irq_s1_d;
            irq_s2_q <= irq_s2_d;
            ctl_s1_q <= ctl_s1_d;
            ctl_s2_q <= ctl_s2_d;
            icr_s1_q <= icr_s1_d;
            icr_s2_q <= icr_s2_d;
            pir_s1_q <= pir_s1_d;
            pir_s2_q <= pir_s2_d;
        end
    end

    psvu_irq_s irq_s;
    logic      soft_rst;
    logic      sleep_s;
    logic      flag_any;
    // synchronised request, control and flag views
    assign irq_s    = psvu_irq_s'(irq_s2_q);
    assign soft_rst = ctl_s2_q[1];
    assign sleep_s  = ctl_s2_q[0];
    assign flag_any = (|icr_s2_q) | (|pir_s2_q);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // address beyond implemented flash
    function automatic logic beyond_flash(input logic [PC_W-1:0] a);
        beyond_flash = ({11'h000, a} >= 32'(FLASH_BYTES));
    endfunction : beyond_flash

    // byte split of a counter value
    function automatic psvu_tos_s split_pc(input logic [PC_W-1:0] a);
        split_pc = psvu_tos_s'({3'b000, a});
    endfunction : split_pc

    // ------------------------------------------------------------
    // sequencer and counter
    // ------------------------------------------------------------
    psvu_state_e     state_q, state_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [SP_W-1:0] sp_q, sp_d;
    logic            full_q, full_d;
    logic            push;
    logic            taken_d;

    // next counter, vector selection, push decision
    always_comb begin
        state_d = state_q;
        pc_d    = pc_q;
        sp_d    = sp_q;
        full_d  = full_q;
        push    = 1'b0;
        taken_d = 1'b0;
        if (soft_rst) begin
            pc_d    = RESET_VECTOR;
            sp_d    = SP_RESET;
            state_d = PSVU_RUN;
        end else begin
            case (state_q)
                PSVU_RUN: begin
                    if (irq_s.high_req && irq_s.high_en) begin
                        pc_d    = HIGH_VECTOR;
                        push    = 1'b1;
                        taken_d = 1'b1;
                    end else if (irq_s.low_req && irq_s.low_en) begin
                        pc_d    = LOW_VECTOR;
                        push    = 1'b1;
                        taken_d = 1'b1;
                    end else if (sleep_s) begin
                        state_d = PSVU_SLEEP;
                    end else if (advance) begin
                        pc_d = pc_q + PC_STEP;
                    end
                end
                PSVU_SLEEP: begin
                    if (flag_any && (irq_s.high_req || irq_s.low_req)) begin
                        state_d = PSVU_RUN;
                        if (irq_s.high_req && irq_s.high_en) begin
                            pc_d    = HIGH_VECTOR;
                            push    = 1'b1;
                            taken_d = 1'b1;
                        end else if (irq_s.low_req && irq_s.low_en) begin
                            pc_d    = LOW_VECTOR;
                            push    = 1'b1;
                            taken_d = 1'b1;
                        end else begin
                            pc_d = pc_q + PC_STEP;
                        end
                    end
                end
                default: state_d = PSVU_RUN;
            endcase
            if (push) begin
                if (sp_q != SP_FULL) begin
                    sp_d = sp_q + 5'h01;
                end
                if (sp_q >= SP_FULL - 5'h01) begin
                    full_d = 1'b1;
                end
            end
        end
        pc_d[0] = 1'b0;
    end

    // counter state registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PSVU_RUN;
            pc_q    <= RESET_VECTOR;
            sp_q    <= SP_RESET;
            full_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            sp_q    <= sp_d;
            full_q  <= full_d;
        end
    end

    // ------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------
    logic [PC_W-1:0] stack_rdata;
    logic            push_ok;
    // a push at the top slot is refused
    assign push_ok = push && (sp_q != SP_FULL);

    psvu_stack_mem #(
        .DEPTH (STACK_DEPTH),
        .AW    (SP_W),
        .DW    (PC_W)
    ) u_stack (
        .clk   (mclk),
        .we    (push_ok),
        .waddr (sp_d),
        .wdata (pc_q),
        .raddr (sp_d),
        .rdata (stack_rdata)
    );

    // ------------------------------------------------------------
    // fetch port and outputs
    // ------------------------------------------------------------
    logic [PC_W-1:0]   addr_q;
    logic [PC_W-1:0]   addr_d;
    logic              beyond_d;
    logic              asleep_d;
    logic              valid_q;
    logic              valid_d;
    logic              beyond_q;
    logic [WORD_W-1:0] word_q, word_d;
    logic              taken_q;
    logic              asleep_q;

    // fetch word, zero above flash; next address and status
    always_comb begin
        valid_d  = rst_n && (state_q == PSVU_RUN);
        word_d   = beyond_q ? NOP_WORD : flash_rdata;
        addr_d   = pc_q;
        beyond_d = beyond_flash(pc_q);
        asleep_d = (state_d == PSVU_SLEEP);
    end

    // fetch address and status registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q   <= RESET_VECTOR;
            valid_q  <= 1'b0;
            beyond_q <= 1'b0;
            word_q   <= NOP_WORD;
            taken_q  <= 1'b0;
            asleep_q <= 1'b0;
        end else begin
            addr_q   <= addr_d;
            valid_q  <= valid_d;
            beyond_q <= beyond_d;
            word_q   <= word_d;
            taken_q  <= taken_d;
            asleep_q <= asleep_d;
        end
    end

    // outputs straight from registers
    assign fetch_addr           = addr_q;
    assign fetch_valid          = valid_q;
    assign fetch_word           = word_q;
    assign tos                  = split_pc(stack_rdata);
    assign return_stack_pointer = sp_q;
    assign stack_full           = full_q;
    assign asleep               = asleep_q;
    assign vector_taken         = taken_q;
endmodule : psvu_top

// ==== test/psvu_flash_model.sv ====
`timescale 1ns/1ps
// program memory on its own fetch bus
module psvu_flash_model
    import psvu_pkg::*;
(
    input  wire logic [PC_W-1:0]   fetch_addr,
    output logic      [WORD_W-1:0] flash_rdata
);
    // never zero, so a zero word can only come from the block
    assign flash_rdata = {fetch_addr[15:1], 1'b1};
endmodule : psvu_flash_model

// ==== test/psvu_top_chk.sv ====
`timescale 1ns/1ps
module psvu_top_chk
    import psvu_pkg::*;
#(
    parameter int FLASH_BYTES = FLASH_64K
) (
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic              soft_reset,
    input wire psvu_irq_s         irq,
    input wire logic [PC_W-1:0]   fetch_addr,
    input wire logic [WORD_W-1:0] fetch_word,
    input wire psvu_tos_s         tos,
    input wire logic [SP_W-1:0]   return_stack_pointer,
    input wire logic              stack_full,
    input wire logic              asleep,
    input wire logic              vector_taken
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_at_reset_vec;
        fetch_addr == RESET_VECTOR && return_stack_pointer == SP_RESET;
    endsequence
    sequence s_no_push_4;
        (!vector_taken && $stable(return_stack_pointer)) [*4];
    endsequence
    logic hi;
    assign hi = irq.high_req & irq.high_en; // high request enabled
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_PC_ALIGN: assert property (fetch_addr[0] == 1'b0)
        else $error("fetch address odd");
    AST_SP_STEP: assert property (return_stack_pointer > $past(return_stack_pointer)
        |-> return_stack_pointer == $past(return_stack_pointer) + 5'h01 ##[0:2] vector_taken)
        else $error("stack pointer step wrong");
    AST_TOS_PAIR: assert property (vector_taken && !stack_full
        |=> {tos.upper, tos.high, tos.low} == {3'h0, $past(fetch_addr)})
        else $error("top of stack not pushed counter");
    AST_HIGH_VEC: assert property (vector_taken && $past(hi, 3)
        |=> fetch_addr == HIGH_VECTOR)
        else $error("high vector wrong");
    AST_LOW_VEC: assert property (vector_taken && !$past(hi, 3)
        |=> fetch_addr == LOW_VECTOR)
        else $error("low vector wrong");
    AST_NOP_ABOVE: assert property (fetch_addr >= FLASH_BYTES && $past(fetch_addr) >= FLASH_BYTES
        && $past(fetch_addr, 2) >= FLASH_BYTES |-> fetch_word == NOP_WORD)
        else $error("fetch above flash not zero");
    AST_SOFT_RST: assert property ($rose(soft_reset) |-> ##[1:8] s_at_reset_vec)
        else $error("soft reset not to vector zero");
    AST_WAKE_NOEN: assert property ($fell(asleep) && !$past(irq.high_en, 3)
        && !$past(irq.low_en, 3)
        |-> s_no_push_4)
        else $error("wake without enable pushed");
endmodule : psvu_top_chk

bind psvu_top psvu_top_chk #(.FLASH_BYTES(FLASH_BYTES)) i_psvu_top_chk (
    .mclk(mclk), .rst_b(rst_b), .soft_reset(soft_reset), .irq(irq),
    .fetch_addr(fetch_addr), .fetch_word(fetch_word), .tos(tos),
    .return_stack_pointer(return_stack_pointer), .stack_full(stack_full),
    .asleep(asleep), .vector_taken(vector_taken));

// ==== test/psvu_top_tb.sv ====
`timescale 1ns/1ps
module psvu_top_tb
    import psvu_pkg::*;
;
    logic              mclk = 1'b0;
    logic              rst_b = 1'b0;
    logic              soft_reset = 1'b0;
    logic              sleep_req = 1'b0;
    logic              advance = 1'b0;
    psvu_irq_s         irq = '0;
    logic [7:0]        ctl_flags = 8'h00;
    logic [7:0]        per_flags = 8'h00;
    logic [WORD_W-1:0] flash_rdata;
    logic [PC_W-1:0]   fetch_addr;
    logic [WORD_W-1:0] fetch_word;
    psvu_tos_s         tos;
    logic [SP_W-1:0]   sp;
    logic              fetch_valid, stack_full, asleep, vector_taken;
    int                miscompares = 0;
    int                n_checks = 0;

    psvu_top #(.FLASH_BYTES(FLASH_32K)) i_psvu_top (
        .mclk(mclk), .rst_b(rst_b), .soft_reset(soft_reset), .sleep_req(sleep_req),
        .advance(advance), .irq(irq), .interrupt_control_regs(ctl_flags),
        .peripheral_irq_flag_regs(per_flags), .flash_rdata(flash_rdata),
        .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .tos(tos), .return_stack_pointer(sp), .stack_full(stack_full),
        .asleep(asleep), .vector_taken(vector_taken));
    psvu_flash_model i_psvu_flash_model (.fetch_addr(fetch_addr), .flash_rdata(flash_rdata));

    // clock and watchdog
    initial begin
        forever #4 mclk = ~mclk;
    end
    initial begin
        #(8 * 40000);
        miscompares++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic step(input int n);
        @(posedge mclk) advance <= 1'b1;
        repeat (n) @(posedge mclk);
        advance <= 1'b0;
        cyc(4);
    endtask : step
    task automatic take(input logic [3:0] req, input logic [20:0] vec);
        logic [20:0] base;
        logic [4:0]  sp0;
        logic        seen;
        base = fetch_addr;
        sp0 = sp;
        seen = 1'b0;
        // one-cycle request: request and enable bits drop on the next clock
        @(posedge mclk) irq <= psvu_irq_s'(req);
        @(posedge mclk) irq <= '0;
        for (int i = 0; i < 30 && !seen; i++) begin
            cyc(1);
            seen = (vector_taken === 1'b1);
        end
        cyc(1);
        chk("vector_taken", 24'h00_0001, 24'(seen));
        chk("fetch_addr", 24'(vec), 24'(fetch_addr));
        chk("tos", 24'(base), {tos.upper, tos.high, tos.low});
        chk("sp", 24'(sp0 + 5'h01), 24'(sp));
        cyc(8);
    endtask : take
    task automatic go_sleep();
        @(posedge mclk) sleep_req <= 1'b1;
        for (int i = 0; i < 20 && asleep !== 1'b1; i++) cyc(1);
        @(posedge mclk) sleep_req <= 1'b0;
        cyc(4);
        chk("asleep", 24'h00_0001, 24'(asleep));
        chk("fetch_valid sleep", 24'h00_0000, 24'(fetch_valid));
    endtask : go_sleep
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_wake_en();
        go_sleep();
        @(posedge mclk) per_flags <= 8'h01;
        take(4'h5, LOW_VECTOR);
        @(posedge mclk) per_flags <= 8'h00;
    endtask : t_wake_en
    task automatic t_wake_noen();
        logic [20:0] base;
        logic [4:0]  sp0;
        go_sleep();
        base = fetch_addr;
        sp0 = sp;
        @(posedge mclk) irq <= psvu_irq_s'(4'h4);
        cyc(10);
        chk("asleep no flag", 24'h00_0001, 24'(asleep));
        @(posedge mclk) ctl_flags <= 8'h80;
        for (int i = 0; i < 20 && asleep !== 1'b0; i++) cyc(1);
        cyc(4);
        chk("fetch_addr wake", 24'(base + PC_STEP), 24'(fetch_addr));
        chk("sp wake", 24'(sp0), 24'(sp));
        @(posedge mclk) irq <= '0;
        ctl_flags <= 8'h00;
        cyc(4);
    endtask : t_wake_noen
    task automatic t_soft();
        @(posedge mclk) soft_reset <= 1'b1;
        cyc(3);
        @(posedge mclk) soft_reset <= 1'b0;
        cyc(8);
        chk("fetch_addr soft", 24'h00_0000, 24'(fetch_addr));
        chk("sp soft", 24'h00_0000, 24'(sp));
    endtask : t_soft
    task automatic t_flash();
        step(16383);
        chk("fetch_addr top", 24'h00_7ffe, 24'(fetch_addr));
        chk("fetch_word top", 24'h00_7fff, 24'(fetch_word));
        step(1);
        chk("fetch_addr above", 24'h00_8000, 24'(fetch_addr));
        chk("fetch_word above", 24'(NOP_WORD), 24'(fetch_word));
    endtask : t_flash
    task automatic t_full();
        for (int i = 0; i < 32; i++) begin
            @(posedge mclk) irq <= psvu_irq_s'(4'ha);
            @(posedge mclk) irq <= '0;
            cyc(4);
        end
        chk("sp full", 24'(SP_FULL), 24'(sp));
        chk("stack_full", 24'h00_0001, 24'(stack_full));
    endtask : t_full
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        cyc(6);
        chk("fetch_addr reset", 24'h00_0000, 24'(fetch_addr));
        chk("fetch_valid run", 24'h00_0001, 24'(fetch_valid));
        chk("sp reset", 24'h00_0000, 24'(sp));
        step(5);
        chk("fetch_addr step", 24'h00_000a, 24'(fetch_addr));
        take(4'ha, HIGH_VECTOR);
        take(4'hf, HIGH_VECTOR);
        take(4'h5, LOW_VECTOR);
        t_wake_en();
        t_wake_noen();
        t_soft();
        t_flash();
        t_full();
        wrap_up();
    end
endmodule : psvu_top_tb
